// [core/scrc_defs.vh]
// register map, opcodes, field positions and limits of the scanner relay controller
`ifndef SCRC_DEFS_VH
`define SCRC_DEFS_VH

// register byte offsets (low eight address bits)
`define SCRC_OFS_CMD      8'h00
`define SCRC_OFS_MASK     8'h04
`define SCRC_OFS_STATUS   8'h08
`define SCRC_OFS_RELAY    8'h0C
`define SCRC_OFS_EXCL     8'h10
`define SCRC_OFS_IND      8'h14
`define SCRC_OFS_SCAN     8'h18
`define SCRC_OFS_EXT_LEN  8'h1C
`define SCRC_OFS_EXT_ADDR 8'h20
`define SCRC_OFS_EXT_DATA 8'h24

// command word fields
`define SCRC_CMD_OP_MSB   3
`define SCRC_CMD_OP_LSB   0
`define SCRC_CMD_ARG_MSB  19
`define SCRC_CMD_ARG_LSB  16
`define SCRC_CMD_LIST_MSB 14
`define SCRC_CMD_LIST_LSB 4

// command opcodes
`define SCRC_OP_EXCL      4'h1
`define SCRC_OP_OPEN_ALL  4'h2
`define SCRC_OP_MCLOSE    4'h3
`define SCRC_OP_MOPEN     4'h4
`define SCRC_OP_INT_LIST  4'h5
`define SCRC_OP_SEL       4'h6

// sweep source selector codes
`define SCRC_SEL_NONE     2'h0
`define SCRC_SEL_INT      2'h1
`define SCRC_SEL_EXT      2'h2

// channel limits
`define SCRC_NUM_CH       11
`define SCRC_IN_CH        10
`define SCRC_POLE_BIT     10
`define SCRC_PAIR_OFS     5
`define SCRC_MAX_PAIR     4'h5
`define SCRC_MAX_CH       4'hA
`define SCRC_INT_MIN      4'h2
`define SCRC_INT_MAX      4'hA
`define SCRC_EXT_MIN      10'h002
`define SCRC_EXT_MAX      10'h320

// ahb transfer size code of a whole word
`define SCRC_HSIZE_WORD   3'h2
`define SCRC_SIZE_WORD    3'h2

`endif

// [core/scrc_ext_mem.v]
// single-port-write, registered-read memory holding the external sweep list
`timescale 1ns/1ps
`default_nettype none

module scrc_ext_mem #(
	parameter AW    = 10,
	parameter DW    = 10,
	parameter DEPTH = 800
) (
	input  wire          clk,    // block clock
	input  wire          ce,     // clock enable, freezes contents and output
	input  wire          we,     // write strobe
	input  wire [AW-1:0] waddr,  // write address
	input  wire [DW-1:0] wdata,  // write data
	input  wire [AW-1:0] raddr,  // read address
	output reg  [DW-1:0] rdata   // registered read data
);

	reg [DW-1:0] mem [0:DEPTH-1];

	// write-first so a read of the word just written sees the new value
	always @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			if (we && (waddr == raddr)) begin
				rdata <= wdata;
			end else begin
				rdata <= mem[raddr];
			end
		end
	end

endmodule // scrc_ext_mem

`default_nettype wire

// [core/scrc_relay_ctrl.v]
// relay and sweep-list controller for a ten-channel scanner card with pole relay, AHB-Lite slave
// Function
// R01: exclusive close opens all closed input channels first, then closes requested one.
// R02: exclusive close: 2-wire accepts 1..10, 4-wire accepts pairs 1..5 only.
// R03: in 4-pole operation pair n closes channel n and n plus five.
// R04: exclusive close lights indicator of closed channel; 4-pole lights lower one only.
// R05: exclusive-close query reports that channel or lower channel of the pair.
// R06: exclusive-close query never reports channels closed by multiple close.
// R07: any close is refused while internal or external sweep is enabled.
// R08: open-all opens channels 1..10, leaves pole relay channel 11 alone.
// R09: open-all also sets sweep source selection to none.
// R10: multiple close closes every listed channel 1..11, several at once allowed.
// R11: multiple path pole mode: channel 11 closed two-pole, open four-pole.
// R12: multiple close turns off the front-panel channel indicators.
// R13: multiple-close query returns all closed channels including pair partners.
// R14: multiple open opens every listed channel 1..11; opening 11 gives four-pole.
// R15: internal list write stores list and enables sweep; two to ten channels.
// R16: internal list must be consecutive channels; gaps are rejected.
// R17: external list holds 2 to 800 entries, each numbered 1 to 800.
// R18: storing external list does not start sweeping; selector must choose external.
// R19: selector has internal, external and none, and reads back.
// R20: rejected request changes no state and raises the error indication.
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "scrc_defs.vh"

module scrc_relay_ctrl #(
	parameter EXT_DEPTH = 800
) (
	input  wire        MCLK,        // block clock, 10 MHz
	input  wire        RESET_N,     // asynchronous reset, active low
	input  wire        CE,          // clock enable, freezes all state while low
	input  wire        FOUR_WIRE,   // present function is four-wire
	input  wire        HSEL,        // ahb slave select
	input  wire [31:0] HADDR,       // ahb address
	input  wire [1:0]  HTRANS,      // ahb transfer type
	input  wire        HWRITE,      // ahb write
	input  wire [2:0]  HSIZE,       // ahb size
	input  wire [31:0] HWDATA,      // ahb write data
	input  wire        HREADY,      // ahb bus ready
	output wire [31:0] HRDATA,      // ahb read data
	output wire        HREADYOUT,   // ahb slave ready
	output wire        HRESP,       // ahb response, always okay
	output wire [10:0] RELAY_CLOSE, // relay drive, bit k is channel k+1
	output wire [9:0]  CHAN_IND,    // front-panel channel indicators
	output wire        FOUR_POLE,   // card pole mode, high for four-pole
	output wire [1:0]  SWEEP_SEL,   // sweep source selection
	output wire        CMD_ERR,     // one-cycle pulse on a rejected request
	output wire        BUSY         // exclusive close sequence in progress
);

	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_OPEN  = 3'b010;
	localparam [2:0] ST_CLOSE = 3'b100;

	// number of set bits in a channel list
	function [3:0] f_popcnt;
		input [10:0] m;
		integer i;
		begin
			f_popcnt = 4'h0;
			for (i = 0; i < 11; i = i + 1) begin
				f_popcnt = f_popcnt + {3'h0, m[i]};
			end
		end
	endfunction

	// index (1..11) of the lowest or highest set bit, zero when empty
	function [3:0] f_edge;
		input [10:0] m;
		input        hi;
		integer i;
		begin
			f_edge = 4'h0;
			for (i = 0; i < 11; i = i + 1) begin
				if (m[i] && (hi || (f_edge == 4'h0))) begin
					f_edge = i[3:0] + 4'h1;
				end
			end
		end
	endfunction

	// relay bits closed by an exclusive close of channel or pair ch
	function [9:0] f_excl_mask;
		input [3:0] ch;
		input       four;
		reg   [9:0] one;
		begin
			one = 10'h001 << (ch - 4'h1);
			f_excl_mask = four ? (one | (one << `SCRC_PAIR_OFS)) : one; // [R03]
		end
	endfunction

	reg  [2:0]  state_r, state_nxt;
	reg  [10:0] relay_r, relay_nxt;
	reg  [9:0]  ind_r, ind_nxt;
	reg  [3:0]  excl_ch_r, excl_ch_nxt;
	reg  [9:0]  pend_mask_r, pend_mask_nxt;
	reg  [3:0]  pend_ch_r, pend_ch_nxt;
	reg  [1:0]  sel_r, sel_nxt;
	reg  [3:0]  int_lo_r, int_lo_nxt;
	reg  [3:0]  int_hi_r, int_hi_nxt;
	reg  [10:0] mask_r;
	reg  [9:0]  ext_len_r;
	reg  [9:0]  ext_addr_r, ext_addr_nxt;
	reg         err_pls_r, err_nxt;
	reg         err_stk_r;
	reg         ok_nxt;
	reg         ap_wr_r;
	reg  [7:0]  ap_adr_r;
	reg  [31:0] hrdata_r;
	reg  [31:0] rd_mux;
	wire [9:0]  ext_rdata;

	// address phase acceptance; only whole-word writes are acted on
	wire        ap_take   = CE & HSEL & HTRANS[1] & HREADY;
	wire        wr_en     = CE & ap_wr_r;
	wire [3:0]  cmd_op    = HWDATA[`SCRC_CMD_OP_MSB:`SCRC_CMD_OP_LSB];
	wire [3:0]  cmd_arg   = HWDATA[`SCRC_CMD_ARG_MSB:`SCRC_CMD_ARG_LSB];
	wire        cmd_go    = wr_en & (ap_adr_r == `SCRC_OFS_CMD);
	wire        ext_len_w = wr_en & (ap_adr_r == `SCRC_OFS_EXT_LEN);
	wire        ext_dat_w = wr_en & (ap_adr_r == `SCRC_OFS_EXT_DATA);
	wire [9:0]  ext_wval  = HWDATA[9:0];
	wire        ext_wok   = (HWDATA[31:10] == 22'h00_0000) && (ext_wval != 10'h000)
	                        && (ext_wval <= `SCRC_EXT_MAX); // [R17]
	wire        ext_lok   = (HWDATA[31:10] == 22'h00_0000) && (ext_wval >= `SCRC_EXT_MIN)
	                        && (ext_wval <= `SCRC_EXT_MAX); // [R17]
	wire        sweeping  = (sel_r != `SCRC_SEL_NONE);
	wire        idle      = state_r[0];
	wire [10:0] mlist     = HWDATA[`SCRC_CMD_LIST_MSB:`SCRC_CMD_LIST_LSB]; // clear of the opcode field
	wire [3:0]  mcnt      = f_popcnt(mlist);
	wire [3:0]  mlo       = f_edge(mlist, 1'b0);
	wire [3:0]  mhi       = f_edge(mlist, 1'b1);

	// command decode and the exclusive close sequence
	always @* begin
		state_nxt     = state_r;
		relay_nxt     = relay_r;
		ind_nxt       = ind_r;
		excl_ch_nxt   = excl_ch_r;
		pend_mask_nxt = pend_mask_r;
		pend_ch_nxt   = pend_ch_r;
		sel_nxt       = sel_r;
		int_lo_nxt    = int_lo_r;
		int_hi_nxt    = int_hi_r;
		err_nxt       = 1'b0;
		ok_nxt        = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (cmd_go) begin
					err_nxt = 1'b1; // cleared below by each accepted command [R20]
					case (cmd_op)
						`SCRC_OP_EXCL: begin
							if (!sweeping && (cmd_arg != 4'h0) &&
							    (cmd_arg <= (FOUR_WIRE ? `SCRC_MAX_PAIR : `SCRC_MAX_CH))) begin // [R02] [R07]
								pend_mask_nxt = f_excl_mask(cmd_arg, FOUR_WIRE);
								pend_ch_nxt   = cmd_arg;
								state_nxt     = ST_OPEN;
								err_nxt       = 1'b0;
							end
						end
						`SCRC_OP_OPEN_ALL: begin
							relay_nxt   = {relay_r[`SCRC_POLE_BIT], 10'h000}; // [R08]
							sel_nxt     = `SCRC_SEL_NONE; // [R09]
							ind_nxt     = 10'h000;
							excl_ch_nxt = 4'h0;
							err_nxt     = 1'b0;
						end
						`SCRC_OP_MCLOSE: begin
							if (!sweeping && (HWDATA[31:15] == 17'h0_0000)) begin // [R07]
								relay_nxt = relay_r | mlist; // [R10] [R11]
								ind_nxt   = 10'h000; // [R12]
								err_nxt   = 1'b0;
							end
						end
						`SCRC_OP_MOPEN: begin
							if (HWDATA[31:15] == 17'h0_0000) begin
								relay_nxt = relay_r & ~mlist; // [R14]
								// stored close mask, since the present function may have changed since
								if ((excl_ch_r != 4'h0) && ((mlist[9:0] & pend_mask_r) != 10'h000)) begin
									excl_ch_nxt = 4'h0;
									ind_nxt     = 10'h000;
								end
								err_nxt = 1'b0;
							end
						end
						`SCRC_OP_INT_LIST: begin
							// consecutive run inside 1..10, length two to ten
							if ((HWDATA[31:14] == 18'h0_0000) && (mcnt >= `SCRC_INT_MIN) &&
							    (mcnt <= `SCRC_INT_MAX) && ((mhi - mlo + 4'h1) == mcnt)) begin // [R15] [R16]
								int_lo_nxt = mlo;
								int_hi_nxt = mhi;
								sel_nxt    = `SCRC_SEL_INT; // [R15]
								err_nxt    = 1'b0;
							end
						end
						`SCRC_OP_SEL: begin
							if (cmd_arg[3:2] == 2'h0 && cmd_arg[1:0] != 2'h3) begin
								sel_nxt = cmd_arg[1:0]; // [R18] [R19]
								err_nxt = 1'b0;
							end
						end
						default: begin
							err_nxt = 1'b1;
						end
					endcase
				end
			end
			ST_OPEN: begin
				relay_nxt = {relay_r[`SCRC_POLE_BIT], 10'h000}; // [R01]
				if (cmd_go) begin
					err_nxt = 1'b1;
				end
				state_nxt = ST_CLOSE;
			end
			ST_CLOSE: begin
				relay_nxt   = {relay_r[`SCRC_POLE_BIT], pend_mask_r}; // [R01]
				ind_nxt     = 10'h001 << (pend_ch_r - 4'h1); // [R04]
				excl_ch_nxt = pend_ch_r; // [R05]
				if (cmd_go) begin
					err_nxt = 1'b1;
				end
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		// external list writes are checked here too; a refused word is not stored
		if ((ext_len_w && !ext_lok) || (ext_dat_w && !ext_wok)) begin
			err_nxt = 1'b1; // [R20]
		end
		ok_nxt = (cmd_go | ext_len_w | ext_dat_w) & ~err_nxt;
	end

	// external list pointer advances on each accepted entry
	always @* begin
		ext_addr_nxt = ext_addr_r;
		if (wr_en && (ap_adr_r == `SCRC_OFS_EXT_ADDR)) begin
			ext_addr_nxt = HWDATA[9:0];
		end else if (ext_dat_w && ext_wok) begin
			ext_addr_nxt = ext_addr_r + 10'h001;
		end
	end

	// relay, indicator and sweep state
	always @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_r     <= ST_IDLE;
			relay_r     <= 11'h000;
			ind_r       <= 10'h000;
			excl_ch_r   <= 4'h0;
			pend_mask_r <= 10'h000;
			pend_ch_r   <= 4'h0;
			sel_r       <= `SCRC_SEL_NONE;
			int_lo_r    <= 4'h0;
			int_hi_r    <= 4'h0;
			err_pls_r   <= 1'b0;
			err_stk_r   <= 1'b0;
		end else if (CE) begin
			state_r     <= state_nxt;
			relay_r     <= relay_nxt;
			ind_r       <= ind_nxt;
			excl_ch_r   <= excl_ch_nxt;
			pend_mask_r <= pend_mask_nxt;
			pend_ch_r   <= pend_ch_nxt;
			sel_r       <= sel_nxt;
			int_lo_r    <= int_lo_nxt;
			int_hi_r    <= int_hi_nxt;
			err_pls_r   <= err_nxt; // [R20]
			// sticky error: a fresh refusal wins over the clear by an accepted one
			if (err_nxt) begin
				err_stk_r <= 1'b1;
			end else if (ok_nxt) begin
				err_stk_r <= 1'b0;
			end
		end
	end

	// software registers and bus address phase capture
	always @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mask_r     <= 11'h000;
			ext_len_r  <= 10'h000;
			ext_addr_r <= 10'h000;
			ap_wr_r    <= 1'b0;
			ap_adr_r   <= 8'h00;
			hrdata_r   <= 32'h0000_0000;
		end else if (CE) begin
			ap_wr_r    <= ap_take & HWRITE & (HSIZE == `SCRC_HSIZE_WORD);
			ext_addr_r <= ext_addr_nxt;
			if (ap_take) begin
				ap_adr_r <= HADDR[7:0];
			end
			if (ap_take && !HWRITE) begin
				hrdata_r <= rd_mux;
			end
			if (wr_en && (ap_adr_r == `SCRC_OFS_MASK)) begin
				mask_r <= HWDATA[10:0];
			end
			if (ext_len_w && ext_lok) begin
				ext_len_r <= ext_wval; // [R17] [R18]
			end
		end
	end

	// read data chosen in the address phase so reads need no wait state
	always @* begin
		case (HADDR[7:0])
			`SCRC_OFS_MASK:     rd_mux = {21'h00_0000, mask_r};
			`SCRC_OFS_STATUS:   rd_mux = {29'h0000_0000, ~idle, err_stk_r, sweeping};
			`SCRC_OFS_RELAY:    rd_mux = {21'h00_0000, relay_r}; // [R13]
			`SCRC_OFS_EXCL:     rd_mux = {28'h000_0000, excl_ch_r}; // [R05] [R06]
			`SCRC_OFS_IND:      rd_mux = {22'h00_0000, ind_r};
			`SCRC_OFS_SCAN:     rd_mux = {14'h0000, sel_r, 8'h00, int_hi_r, int_lo_r}; // [R19]
			`SCRC_OFS_EXT_LEN:  rd_mux = {22'h00_0000, ext_len_r};
			`SCRC_OFS_EXT_ADDR: rd_mux = {22'h00_0000, ext_addr_r};
			`SCRC_OFS_EXT_DATA: rd_mux = {22'h00_0000, ext_rdata};
			default:            rd_mux = 32'h0000_0000;
		endcase
	end

	// external sweep list store; read port follows the pointer's next value
	scrc_ext_mem #(
		.AW    (10),
		.DW    (10),
		.DEPTH (EXT_DEPTH)
	) u_ext_mem (
		.clk   (MCLK),
		.ce    (CE),
		.we    (ext_dat_w & ext_wok), // [R17]
		.waddr (ext_addr_r),
		.wdata (ext_wval),
		.raddr (ext_addr_nxt),
		.rdata (ext_rdata)
	);

	// bus is held off only while the block is frozen
	assign HRDATA      = hrdata_r;
	assign HREADYOUT   = CE;
	assign HRESP       = 1'b0;
	assign RELAY_CLOSE = relay_r;
	assign CHAN_IND    = ind_r;
	assign FOUR_POLE   = ~relay_r[`SCRC_POLE_BIT]; // [R11] [R14]
	assign SWEEP_SEL   = sel_r;
	assign CMD_ERR     = err_pls_r;
	assign BUSY        = ~idle;

endmodule // scrc_relay_ctrl

`default_nettype wire

// [verification/scrc_properties.sv]
// concurrent checks on the ports of the scanner relay controller
`timescale 1ns/1ps
`default_nettype none
`include "scrc_defs.vh"

module scrc_properties #(
	parameter EXT_DEPTH = 800
) (
	input wire logic        MCLK,        // block clock
	input wire logic        RESET_N,     // reset, active low
	input wire logic        CE,          // clock enable
	input wire logic        FOUR_WIRE,   // four-wire function
	input wire logic        HSEL,        // slave select
	input wire logic [31:0] HADDR,       // bus address
	input wire logic [1:0]  HTRANS,      // transfer type
	input wire logic        HWRITE,      // write strobe
	input wire logic [31:0] HWDATA,      // write data
	input wire logic        HREADY,      // bus ready
	input wire logic [10:0] RELAY_CLOSE, // relay drive
	input wire logic [9:0]  CHAN_IND,    // indicators
	input wire logic        FOUR_POLE,   // pole mode
	input wire logic [1:0]  SWEEP_SEL,   // sweep source
	input wire logic        CMD_ERR,     // refusal pulse
	input wire logic        BUSY         // exclusive sequence
);
	logic       wr_r;  // data phase of a write
	logic [7:0] adr_r; // offset of that write
	wire        cmd_w = wr_r && adr_r == `SCRC_OFS_CMD && CE && !BUSY;
	wire  [3:0] op_w  = HWDATA[3:0];

	// keep the address phase, since the data only arrives one cycle later
	always @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wr_r  <= 1'b0;
			adr_r <= 8'h00;
		end else if (CE) begin
			wr_r  <= HSEL && HTRANS[1] && HREADY && HWRITE;
			adr_r <= HADDR[7:0];
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);

	pole_relay_a:
	assert property (FOUR_POLE == !RELAY_CLOSE[10]) else $error("pole mode differs from relay 11");
	open_all_a:
	assert property (cmd_w && op_w == `SCRC_OP_OPEN_ALL |=> RELAY_CLOSE[9:0] == 10'h000
		&& SWEEP_SEL == `SCRC_SEL_NONE && $stable(RELAY_CLOSE[10])) else $error("open all wrong");
	multi_close_a:
	assert property (cmd_w && op_w == `SCRC_OP_MCLOSE && SWEEP_SEL == `SCRC_SEL_NONE |=> CHAN_IND == 10'h000
		&& (RELAY_CLOSE & $past(HWDATA[14:4])) == $past(HWDATA[14:4])) else $error("multi close wrong");
	multi_open_a:
	assert property (cmd_w && op_w == `SCRC_OP_MOPEN |=> (RELAY_CLOSE & $past(HWDATA[14:4])) == 11'h000)
		else $error("multi open left a relay closed");
	sweep_refuse_a:
	assert property (cmd_w && (op_w == `SCRC_OP_EXCL || op_w == `SCRC_OP_MCLOSE) && SWEEP_SEL != `SCRC_SEL_NONE
		|=> CMD_ERR && $stable(RELAY_CLOSE)) else $error("close while sweeping not refused");
	pair_range_a:
	assert property (cmd_w && op_w == `SCRC_OP_EXCL && FOUR_WIRE && HWDATA[19:16] > `SCRC_MAX_PAIR
		|=> CMD_ERR && !BUSY) else $error("bad pair not refused");
	excl_open_a:
	assert property ($rose(BUSY) |=> RELAY_CLOSE[9:0] == 10'h000) else $error("channels not opened first");
	excl_close_a:
	assert property ($fell(BUSY) |-> $onehot(CHAN_IND) && RELAY_CLOSE[9:0] ==
		(FOUR_WIRE ? ({CHAN_IND[4:0], 5'h00} | CHAN_IND) : CHAN_IND)) else $error("exclusive close wrong");
	ext_nostart_a:
	assert property (wr_r && CE && (adr_r == `SCRC_OFS_EXT_DATA || adr_r == `SCRC_OFS_EXT_LEN)
		|=> $stable(SWEEP_SEL)) else $error("external list started a sweep");

	cover property ($fell(BUSY) && FOUR_WIRE);
	cover property (cmd_w && op_w == `SCRC_OP_MCLOSE);
	cover property (CMD_ERR && SWEEP_SEL != `SCRC_SEL_NONE);
endmodule // scrc_properties
`default_nettype wire

// [verification/scrc_card_model.sv]
// contact model of the scanner card relays
`timescale 1ns/1ps
`default_nettype none

module scrc_card_model (
	input wire logic        clk,     // card clock
	input wire logic        rst_n,   // reset, active low
	input wire logic [10:0] drive,   // coil drive
	output logic     [10:0] contact  // contact state
);
	// contacts lag the coil by a cycle, like a slow armature
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) contact <= 11'h000;
		else contact <= drive;
	end
endmodule // scrc_card_model
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the scanner relay controller
`timescale 1ns/1ps
`default_nettype none
`include "scrc_defs.vh"

module tb_top;
	logic MCLK = 0, RESET_N = 0, FOUR_WIRE = 0, HSEL = 0, HWRITE = 0;
	logic [31:0] HADDR = 0, HWDATA = 0, q;
	logic [1:0]  HTRANS = 0, m_sel;
	wire  [31:0] HRDATA;
	wire         HREADYOUT, HRESP, FOUR_POLE, CMD_ERR, BUSY;
	wire  [10:0] RELAY_CLOSE, contact;
	wire  [9:0]  CHAN_IND;
	wire  [1:0]  SWEEP_SEL;
	logic [10:0] m_rel, m_emask;
	logic [9:0]  m_ind;
	logic [3:0]  m_excl;
	logic        err;
	int          err_count = 0, n_tests = 0, i;

	scrc_relay_ctrl #(.EXT_DEPTH(800)) dut (.MCLK(MCLK), .RESET_N(RESET_N), .CE(1'b1), .FOUR_WIRE(FOUR_WIRE),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RELAY_CLOSE(RELAY_CLOSE),
		.CHAN_IND(CHAN_IND), .FOUR_POLE(FOUR_POLE), .SWEEP_SEL(SWEEP_SEL), .CMD_ERR(CMD_ERR), .BUSY(BUSY));
	scrc_card_model card (.clk(MCLK), .rst_n(RESET_N), .drive(RELAY_CLOSE), .contact(contact));

	initial begin
		forever #50 MCLK = ~MCLK;
	end

	task end_sim;
		if (err_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	// one single transfer; entered just after a rising edge, leaves just after one
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		HSEL <= 1'b1; HTRANS <= 2'h2; HWRITE <= w; HADDR <= {24'h00_0000, a};
		do begin @(posedge MCLK); k++; end while (HREADYOUT !== 1'b1 && k < 20);
		HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= d;
		do begin @(posedge MCLK); k++; end while (HREADYOUT !== 1'b1 && k < 20);
		q = HRDATA;
		if (k >= 20) begin err_count++; end_sim; end
		@(negedge MCLK);
		err = CMD_ERR;
		@(posedge MCLK);
	endtask

	// command with its model step, then waits out the exclusive sequence
	task cmd(input logic [3:0] op, input logic [3:0] a, input logic [10:0] r);
		logic [31:0] w;
		logic        e;
		int          lo, n, k;
		w = {12'h000, a, 1'b0, r, op};
		e = 0;
		case (op)
			`SCRC_OP_EXCL: if (m_sel != 0 || a < 1 || a > (FOUR_WIRE ? 5 : 10)) e = 1;
			else begin
				m_rel = (m_rel & 11'h400) | (11'h1 << (a - 1)) | (FOUR_WIRE ? 11'h1 << (a + 4) : 11'h0);
				m_ind = 10'h1 << (a - 1);
				m_excl = a;
				m_emask = m_rel & 11'h3FF;
			end
			`SCRC_OP_MCLOSE: if (m_sel != 0) e = 1;
			else begin m_rel |= r; m_ind = 0; end
			`SCRC_OP_MOPEN: begin
				m_rel &= ~r;
				if ((m_emask & r) != 0) m_excl = 0;
			end
			`SCRC_OP_OPEN_ALL: begin m_rel &= 11'h400; m_sel = 0; m_excl = 0; end
			`SCRC_OP_INT_LIST: begin
				lo = 0;
				while (lo < 10 && !r[lo]) lo++;
				n = $countones(r[9:0]);
				if (r[10] || n < 2 || (r[9:0] >> lo) != (1 << n) - 1) e = 1;
				else m_sel = `SCRC_SEL_INT;
			end
			default: if (a > 2) e = 1;
			else m_sel = a[1:0];
		endcase
		bus(1'b1, `SCRC_OFS_CMD, w);
		chk(32'(err), 32'(e));
		k = 0;
		@(negedge MCLK);
		while (BUSY !== 1'b0) begin
			if (++k > 20) begin err_count++; end_sim; end
			@(negedge MCLK);
		end
		@(posedge MCLK);
		chk(32'(SWEEP_SEL), 32'(m_sel));
		if (!e && (op == `SCRC_OP_EXCL || op == `SCRC_OP_MCLOSE)) chk(32'(CHAN_IND), 32'(m_ind));
		bus(1'b0, `SCRC_OFS_EXCL, 0);
		chk(q, 32'(m_excl));
		bus(1'b0, `SCRC_OFS_RELAY, 0);
		chk(q, 32'(m_rel));
		chk(32'(contact), 32'(m_rel));
		chk(32'(FOUR_POLE), 32'(!m_rel[10]));
	endtask

	initial begin
		repeat (100000) @(posedge MCLK);
		err_count++;
		end_sim;
	end

	initial begin
		m_rel = 0; m_ind = 0; m_excl = 0; m_emask = 0; m_sel = 0; err = 0;
		repeat (20) @(posedge MCLK);
		RESET_N <= 1'b1;
		@(posedge MCLK);
		void'($urandom(33049));
		chk(32'({RELAY_CLOSE, FOUR_POLE, SWEEP_SEL}), 32'h0000_0004);
		for (i = 0; i <= 11; i++) cmd(`SCRC_OP_EXCL, 4'(i), 11'h000);
		cmd(`SCRC_OP_MCLOSE, 4'h0, 11'($urandom));
		cmd(`SCRC_OP_MOPEN, 4'h0, 11'($urandom));
		cmd(`SCRC_OP_MCLOSE, 4'h0, 11'h400);
		FOUR_WIRE <= 1'b1;
		@(posedge MCLK);
		for (i = 0; i <= 6; i++) cmd(`SCRC_OP_EXCL, 4'(i), 11'h000);
		cmd(`SCRC_OP_MCLOSE, 4'h0, 11'($urandom));
		cmd(`SCRC_OP_SEL, 4'h1, 11'h000);
		cmd(`SCRC_OP_EXCL, 4'h2, 11'h000);
		cmd(`SCRC_OP_MCLOSE, 4'h0, 11'h7F0);
		cmd(`SCRC_OP_MOPEN, 4'h0, 11'($urandom));
		cmd(`SCRC_OP_SEL, 4'h3, 11'h000);
		cmd(`SCRC_OP_OPEN_ALL, 4'h0, 11'h000);
		cmd(`SCRC_OP_INT_LIST, 4'h0, 11'h03C);
		cmd(`SCRC_OP_INT_LIST, 4'h0, 11'h00B);
		bus(1'b0, `SCRC_OFS_SCAN, 0);
		chk(32'(q[7:0]), 32'h0000_0063);
		for (i = 0; i < 4; i++) cmd(`SCRC_OP_INT_LIST, 4'h0, 11'($urandom));
		cmd(`SCRC_OP_OPEN_ALL, 4'h0, 11'h000);
		bus(1'b1, `SCRC_OFS_EXT_LEN, 32'h0000_0001);
		chk(32'(err), 32'h0000_0001);
		bus(1'b1, `SCRC_OFS_EXT_LEN, 32'h0000_0320);
		chk(32'(err), 32'h0000_0000);
		bus(1'b0, `SCRC_OFS_EXT_LEN, 0);
		chk(q, 32'h0000_0320);
		bus(1'b1, `SCRC_OFS_EXT_ADDR, 0);
		bus(1'b1, `SCRC_OFS_EXT_DATA, 0);
		chk(32'(err), 32'h0000_0001);
		bus(1'b1, `SCRC_OFS_EXT_DATA, 32'h0000_0320);
		chk(32'({err, SWEEP_SEL}), 32'h0000_0000);
		bus(1'b0, `SCRC_OFS_EXT_ADDR, 0);
		chk(q, 32'h0000_0001);
		cmd(`SCRC_OP_SEL, 4'h2, 11'h000);
		bus(1'b0, `SCRC_OFS_SCAN, 0);
		chk(32'(q[17:16]), 32'h0000_0002);
		bus(1'b0, 8'h40, 0);
		chk(q, 32'h0000_0000);
		cmd(`SCRC_OP_OPEN_ALL, 4'h0, 11'h000);
		end_sim;
	end
endmodule // tb_top

bind scrc_relay_ctrl scrc_properties #(.EXT_DEPTH(EXT_DEPTH)) u_prop (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE),
	.FOUR_WIRE(FOUR_WIRE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
	.HREADY(HREADY), .RELAY_CLOSE(RELAY_CLOSE), .CHAN_IND(CHAN_IND), .FOUR_POLE(FOUR_POLE),
	.SWEEP_SEL(SWEEP_SEL), .CMD_ERR(CMD_ERR), .BUSY(BUSY));
`default_nettype wire
